// [inc/vpwr_pkg.sv]
// constants, register map and state type of the vehicle power manager
// assumes a 50 MHz system clock and a word-addressed avalon-mm slave port
`default_nettype none

package vpwr_pkg;

	// ==================================================================
	// clock and timebase
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned TICK_PERIOD_MS = 1000;
	localparam int unsigned TICK_CYC = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

	// ==================================================================
	// widths
	localparam int unsigned DLY_W = 15;
	localparam int unsigned THR_W = 12;
	localparam int unsigned ADR_W = 4;

	// ==================================================================
	// register word indices (byte address = 4 * index)
	localparam logic [ADR_W-1:0] REG_CTRL     = 4'h0;
	localparam logic [ADR_W-1:0] REG_STATUS   = 4'h1;
	localparam logic [ADR_W-1:0] REG_IRQ_STAT = 4'h2;
	localparam logic [ADR_W-1:0] REG_IRQ_MASK = 4'h3;
	localparam logic [ADR_W-1:0] REG_ON_DLY   = 4'h4;
	localparam logic [ADR_W-1:0] REG_WARN_DLY = 4'h5;
	localparam logic [ADR_W-1:0] REG_HARD_DLY = 4'h6;
	localparam logic [ADR_W-1:0] REG_LOW_DLY  = 4'h7;
	localparam logic [ADR_W-1:0] REG_LOWH_DLY = 4'h8;
	localparam logic [ADR_W-1:0] REG_THRESH   = 4'h9;
	localparam logic [ADR_W-1:0] REG_COUNT    = 4'ha;

	// ==================================================================
	// field positions
	localparam int unsigned CTRL_MODE24 = 0;
	localparam int unsigned ST_POWER    = 0;
	localparam int unsigned ST_IGN      = 1;
	localparam int unsigned ST_BATLOW   = 2;
	localparam int unsigned ST_STATE    = 4;
	localparam int unsigned IRQ_W       = 4;
	localparam int unsigned EV_BUTTON   = 0;
	localparam int unsigned EV_PWR_ON   = 1;
	localparam int unsigned EV_PWR_OFF  = 2;
	localparam int unsigned EV_BATLOW   = 3;

	// ==================================================================
	// defaults and limits; delays in seconds, thresholds in 10 mV
	localparam logic [DLY_W-1:0] ON_DLY_RST   = 15'h0002;
	localparam logic [DLY_W-1:0] WARN_DLY_RST = 15'h0005;
	localparam logic [DLY_W-1:0] HARD_DLY_RST = 15'h003c;
	localparam logic [DLY_W-1:0] LOW_DLY_RST  = 15'h001e;
	localparam logic [DLY_W-1:0] LOWH_DLY_RST = 15'h003c;
	localparam logic [DLY_W-1:0] DLY_MIN      = 15'h0001;
	localparam logic [DLY_W-1:0] IGN_DLY_MAX  = 15'h4650;
	localparam logic [DLY_W-1:0] LOW_DLY_MAX  = 15'h0e10;
	localparam logic [THR_W-1:0] THR12_RST    = 12'h476;
	localparam logic [THR_W-1:0] THR12_MIN    = 12'h3f1;
	localparam logic [THR_W-1:0] THR12_MAX    = 12'h4c9;
	localparam logic [THR_W-1:0] THR24_RST    = 12'h8c4;
	localparam logic [THR_W-1:0] THR24_MIN    = 12'h83f;
	localparam logic [THR_W-1:0] THR24_MAX    = 12'h918;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

	// ==================================================================
	// sequencer states
	typedef enum logic [2:0] {
		ST_OFF,
		ST_ON_WAIT,
		ST_ON,
		ST_OFF_WARN,
		ST_HARD_OFF,
		ST_LOW_WARN,
		ST_LOW_HARD
	} vpwr_state_t;

endpackage

`default_nettype wire

// [rtl/vpwr_sync.sv]
// two-flop synchroniser for one asynchronous level
// assumes the input is a slow level such as the ignition line
`default_nettype none

module vpwr_sync (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// level in and out
	input  wire logic d_i,
	output logic      q_o
);

	// ==================================================================
	// flops
	logic meta_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= 1'b0;
			q_o    <= 1'b0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end

endmodule

`default_nettype wire

// [rtl/vpwr_tick.sv]
// one-second timebase: one-cycle enable pulse every DIV clocks
// assumes clr_i restarts the second so a fresh countdown gets full seconds
`default_nettype none

module vpwr_tick #(
	parameter int unsigned DIV = 50000000
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// control and tick
	input  wire logic clr_i,
	output logic      tick_o
);

	// ==================================================================
	// divider
	logic [31:0] cnt_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q  <= 32'h0;
			tick_o <= 1'b0;
		end else if (clr_i) begin
			cnt_q  <= 32'h0;
			tick_o <= 1'b0;
		end else if (cnt_q == 32'(DIV - 1)) begin
			cnt_q  <= 32'h0;
			tick_o <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 32'h1;
			tick_o <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// [rtl/vpwr_manager.sv]
// vehicle power manager: ignition and battery driven power sequencer
// assumes battery_i is a 10 mV code from same-clock logic, ignition is a pin
`default_nettype none

module vpwr_manager
	import vpwr_pkg::*;
#(
	parameter int unsigned TICK_DIV = TICK_CYC
) (
	// clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// avalon-mm slave
	input  wire logic [ADR_W-1:0]        avs_address_i,
	input  wire logic                    avs_read_i,
	input  wire logic                    avs_write_i,
	input  wire logic [31:0]             avs_writedata_i,
	input  wire logic [3:0]              avs_byteenable_i,
	output logic      [31:0]             avs_readdata_o,
	output logic                         avs_waitrequest_o,
	// vehicle side
	input  wire logic                    ignition_i,
	input  wire logic [THR_W-1:0]        battery_i,
	output logic                         sys_power_o,
	// host side
	output logic                         pwr_button_o,
	output logic                         irq_o
);

	// ==================================================================
	// functions
	function automatic logic [DLY_W-1:0] clamp_dly(input logic [31:0] v,
	                                               input logic [DLY_W-1:0] hi);
		if (v < 32'(DLY_MIN))
			return DLY_MIN;
		else if (v > 32'(hi))
			return hi;
		else
			return v[DLY_W-1:0];
	endfunction

	function automatic logic [THR_W-1:0] clamp_thr(input logic [31:0] v,
	                                               input logic mode24);
		logic [THR_W-1:0] lo;
		logic [THR_W-1:0] hi;
		lo = mode24 ? THR24_MIN : THR12_MIN;
		hi = mode24 ? THR24_MAX : THR12_MAX;
		if (v < 32'(lo))
			return lo;
		else if (v > 32'(hi))
			return hi;
		else
			return v[THR_W-1:0];
	endfunction

	// ==================================================================
	// declarations
	logic              ign_s;
	logic              tick;
	logic              bus_req;
	logic              bus_do;
	logic              wr_en;
	logic              rd_stat;
	logic              expire;
	logic              bat_low;
	logic              state_chg;
	logic [31:0]       rd_mux;
	logic [IRQ_W-1:0]  ev;
	logic              forced_cut;
	logic [IRQ_W-1:0]  stat_clr;
	logic [IRQ_W-1:0]  stat_d;

	vpwr_state_t       state_q;
	vpwr_state_t       state_d;
	logic [DLY_W-1:0]  cnt_q;
	logic              rearm_q;
	logic              mode24_q;
	logic [DLY_W-1:0]  on_dly_q;
	logic [DLY_W-1:0]  warn_dly_q;
	logic [DLY_W-1:0]  hard_dly_q;
	logic [DLY_W-1:0]  low_dly_q;
	logic [DLY_W-1:0]  lowh_dly_q;
	logic [THR_W-1:0]  thr_q;
	logic [IRQ_W-1:0]  irq_stat_q;
	logic [IRQ_W-1:0]  irq_mask_q;

	// ==================================================================
	// ignition pin and timebase
	vpwr_sync u_ign_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (ignition_i),
		.q_o   (ign_s)
	);

	// restart the second on each stage change so no countdown runs short
	assign state_chg = (state_d != state_q);

	vpwr_tick #(
		.DIV (TICK_DIV)
	) u_tick (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.clr_i  (state_chg),
		.tick_o (tick)
	);

	// ==================================================================
	// bus handshake: one wait cycle, access lands when waitrequest is low
	assign bus_req = avs_read_i | avs_write_i;
	assign bus_do  = bus_req & ~avs_waitrequest_o;
	assign wr_en   = bus_do & avs_write_i & (&avs_byteenable_i);
	assign rd_stat = bus_do & avs_read_i & (avs_address_i == REG_IRQ_STAT);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
		end
	end

	always_comb begin
		rd_mux = 32'h0;
		case (avs_address_i)
			REG_CTRL:     rd_mux[CTRL_MODE24] = mode24_q;
			REG_STATUS: begin
				rd_mux[ST_POWER]          = sys_power_o;
				rd_mux[ST_IGN]            = ign_s;
				rd_mux[ST_BATLOW]         = bat_low;
				rd_mux[ST_STATE +: 3]     = state_q;
			end
			REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_q;
			REG_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_q;
			REG_ON_DLY:   rd_mux[DLY_W-1:0] = on_dly_q;
			REG_WARN_DLY: rd_mux[DLY_W-1:0] = warn_dly_q;
			REG_HARD_DLY: rd_mux[DLY_W-1:0] = hard_dly_q;
			REG_LOW_DLY:  rd_mux[DLY_W-1:0] = low_dly_q;
			REG_LOWH_DLY: rd_mux[DLY_W-1:0] = lowh_dly_q;
			REG_THRESH:   rd_mux[THR_W-1:0] = thr_q;
			REG_COUNT:    rd_mux[DLY_W-1:0] = cnt_q;
			default:      rd_mux = 32'h0;
		endcase
	end

	// read data sampled when waitrequest drops, held for the master
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h0;
		end else if (bus_req & avs_waitrequest_o & avs_read_i) begin
			avs_readdata_o <= rd_mux;
		end
	end

	// ==================================================================
	// programmable parameters
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode24_q   <= 1'b0;
			on_dly_q   <= ON_DLY_RST;
			warn_dly_q <= WARN_DLY_RST;
			hard_dly_q <= HARD_DLY_RST;
			low_dly_q  <= LOW_DLY_RST;
			lowh_dly_q <= LOWH_DLY_RST;
			thr_q      <= THR12_RST;
			irq_mask_q <= IRQ_MASK_RST;
		end else if (wr_en) begin
			case (avs_address_i)
				REG_CTRL: begin
					// a mode change picks that mode's default threshold
					mode24_q <= avs_writedata_i[CTRL_MODE24];
					if (avs_writedata_i[CTRL_MODE24] != mode24_q)
						thr_q <= avs_writedata_i[CTRL_MODE24] ? THR24_RST : THR12_RST;
				end
				REG_IRQ_MASK: irq_mask_q <= avs_writedata_i[IRQ_W-1:0];
				REG_ON_DLY:   on_dly_q   <= clamp_dly(avs_writedata_i, IGN_DLY_MAX);
				REG_WARN_DLY: warn_dly_q <= clamp_dly(avs_writedata_i, IGN_DLY_MAX);
				REG_HARD_DLY: hard_dly_q <= clamp_dly(avs_writedata_i, IGN_DLY_MAX);
				REG_LOW_DLY:  low_dly_q  <= clamp_dly(avs_writedata_i, LOW_DLY_MAX);
				REG_LOWH_DLY: lowh_dly_q <= clamp_dly(avs_writedata_i, LOW_DLY_MAX);
				REG_THRESH:   thr_q      <= clamp_thr(avs_writedata_i, mode24_q);
				default: begin
				end
			endcase
		end
	end

	// ==================================================================
	// sequencer
	assign bat_low = (battery_i < thr_q);
	assign expire  = tick & (cnt_q == DLY_MIN);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_OFF:
				if (ign_s & rearm_q)
					state_d = ST_ON_WAIT;
			ST_ON_WAIT:
				if (!ign_s)
					state_d = ST_OFF;
				else if (expire)
					state_d = ST_ON;
			ST_ON:
				if (!ign_s)
					state_d = ST_OFF_WARN;
				else if (bat_low)
					state_d = ST_LOW_WARN;
			ST_OFF_WARN:
				if (ign_s)
					state_d = ST_ON;
				else if (expire)
					state_d = ST_HARD_OFF;
			ST_HARD_OFF:
				// ignition is not looked at here on purpose
				if (expire)
					state_d = ST_OFF;
			ST_LOW_WARN:
				if (!bat_low)
					state_d = ST_ON;
				else if (expire)
					state_d = ST_LOW_HARD;
			ST_LOW_HARD:
				if (expire)
					state_d = ST_OFF;
			default:
				state_d = ST_OFF;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// countdown: loaded on entry, so a re-entered warning starts full
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= DLY_MIN;
		end else if (state_chg) begin
			case (state_d)
				ST_ON_WAIT:  cnt_q <= on_dly_q;
				ST_OFF_WARN: cnt_q <= warn_dly_q;
				ST_HARD_OFF: cnt_q <= hard_dly_q;
				ST_LOW_WARN: cnt_q <= low_dly_q;
				ST_LOW_HARD: cnt_q <= lowh_dly_q;
				default:     cnt_q <= DLY_MIN;
			endcase
		end else if (tick & (cnt_q != DLY_MIN)) begin
			cnt_q <= cnt_q - DLY_MIN;
		end
	end

	// ==================================================================
	// rearm
	// any return to off except an aborted power-up is a forced cut
	assign forced_cut = state_chg & (state_d == ST_OFF) & (state_q != ST_ON_WAIT);

	// after a forced cut the ignition must drop before a new power-up
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rearm_q <= 1'b1;
		end else if (forced_cut) begin
			rearm_q <= 1'b0;
		end else if (!ign_s) begin
			rearm_q <= 1'b1;
		end
	end

	// ==================================================================
	// outputs
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sys_power_o <= 1'b0;
		end else begin
			sys_power_o <= (state_d != ST_OFF) & (state_d != ST_ON_WAIT);
		end
	end

	// button press held from the event until the next second tick
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pwr_button_o <= 1'b0;
		end else if (ev[EV_BUTTON]) begin
			pwr_button_o <= 1'b1;
		end else if (tick) begin
			pwr_button_o <= 1'b0;
		end
	end

	// ==================================================================
	// interrupts: sticky, cleared by reading, set wins over the clear
	always_comb begin
		ev             = '0;
		ev[EV_BUTTON]  = state_chg & ((state_d == ST_HARD_OFF) | (state_d == ST_LOW_HARD));
		ev[EV_PWR_ON]  = state_chg & (state_q == ST_ON_WAIT) & (state_d == ST_ON);
		ev[EV_PWR_OFF] = forced_cut;
		ev[EV_BATLOW]  = state_chg & (state_d == ST_LOW_WARN);
	end

	// a read clears only the bits it returned, so an event landing
	// in the wait cycle survives; a new event still beats the clear
	assign stat_clr = rd_stat ? avs_readdata_o[IRQ_W-1:0] : '0;
	assign stat_d   = (irq_stat_q & ~stat_clr) | ev;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= stat_d;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(stat_d & irq_mask_q);
		end
	end

endmodule

`default_nettype wire

// [tb/vpwr_manager_assertions.sv]
// port checker for the vehicle power manager
// assumes it is bound onto every vpwr_manager instance
`default_nettype none

module vpwr_manager_assertions
	import vpwr_pkg::*;
#(
	parameter int unsigned TICK_DIV = 20
) (
	// clock and reset
	input wire logic             clk_i,
	input wire logic             rst_i,
	// bus
	input wire logic [ADR_W-1:0] avs_address_i,
	input wire logic             avs_read_i,
	input wire logic             avs_write_i,
	input wire logic [31:0]      avs_readdata_o,
	input wire logic             avs_waitrequest_o,
	// vehicle and host
	input wire logic             ignition_i,
	input wire logic             sys_power_o,
	input wire logic             pwr_button_o,
	input wire logic             irq_o
);
	// button may outlive the tick by the register stage
	localparam int BTN_MAX = TICK_DIV + 4;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ====
	// bus
	property p_take;
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
	endproperty
	a_take: assert property (p_take) else $error("request not answered");
	property p_one;
		!avs_waitrequest_o |=> avs_waitrequest_o;
	endproperty
	a_one: assert property (p_one) else $error("answer longer than a cycle");
	property p_idle;
		!$past(avs_read_i) && !$past(avs_write_i) |-> avs_waitrequest_o;
	endproperty
	a_idle: assert property (p_idle) else $error("answer without request");
	property p_rdz;
		avs_read_i && !avs_waitrequest_o && avs_address_i == REG_IRQ_MASK
			|-> avs_readdata_o[31:IRQ_W] == '0;
	endproperty
	a_rdz: assert property (p_rdz) else $error("mask upper bits set");

	// ====
	// sequencer
	property p_on;
		$rose(sys_power_o) |-> $past(ignition_i, 8);
	endproperty
	a_on: assert property (p_on) else $error("power on without ignition");
	property p_stay;
		$rose(sys_power_o) |=> sys_power_o [*8];
	endproperty
	a_stay: assert property (p_stay) else $error("power dropped at once");
	property p_hold;
		$rose(pwr_button_o) |-> (sys_power_o && pwr_button_o) [*8];
	endproperty
	a_hold: assert property (p_hold) else $error("button short or unpowered");
	property p_btnend;
		$rose(pwr_button_o) |-> ##[1:BTN_MAX] !pwr_button_o;
	endproperty
	a_btnend: assert property (p_btnend) else $error("button held too long");

	c_on: cover property ($rose(sys_power_o));
	c_cut: cover property ($fell(sys_power_o));
	c_irq: cover property ($rose(irq_o));
endmodule

bind vpwr_manager vpwr_manager_assertions #(.TICK_DIV(TICK_DIV)) vpwr_manager_assertions_i (
	.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .ignition_i(ignition_i),
	.sys_power_o(sys_power_o), .pwr_button_o(pwr_button_o), .irq_o(irq_o));

`default_nettype wire

// [tb/vpwr_host_model.sv]
// host model: power rail and power-button input
// assumes both lines come from the manager's clock domain
`default_nettype none

module vpwr_host_model (
	// clock and reset
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	// from the manager
	input  wire logic  sys_power_i,
	input  wire logic  pwr_button_i,
	// to the bench
	output logic       rail_o,
	output logic [7:0] presses_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic btn_q;

	// host never acknowledges; a press only counts while powered
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			btn_q <= 1'b0;
			rail_o <= 1'b0;
			presses_o <= 8'h00;
		end else begin
			btn_q <= pwr_button_i;
			rail_o <= sys_power_i;
			if (pwr_button_i && !btn_q && rail_o) begin
				presses_o <= presses_o + 8'h01;
			end
		end
	end
endmodule

`default_nettype wire

// [tb/vpwr_manager_test.sv]
// self-checking bench for the vehicle power manager
// assumes a short tick divider so one second lasts TD clocks
`default_nettype none

module vpwr_manager_test
	import vpwr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned TD = 20;
	logic             clk_i = 1'b0;
	logic             rst_i = 1'b1;
	logic [ADR_W-1:0] adr = '0;
	logic             rd = 1'b0;
	logic             wr = 1'b0;
	logic [31:0]      wdat = '0;
	logic [3:0]       be = 4'hf;
	logic             ign = 1'b0;
	logic [THR_W-1:0] bat = 12'h4b0;
	logic [31:0]      rdat;
	logic             wreq, pwr, btn, irq, rail;
	logic [7:0]       presses;
	int               fails = 0;
	int               comparisons = 0;
	logic [31:0]      notes[$];
	localparam logic [ADR_W-1:0] RA[14] = '{REG_ON_DLY, REG_WARN_DLY, REG_HARD_DLY,
		REG_LOW_DLY, REG_LOWH_DLY, REG_THRESH, REG_IRQ_MASK, 4'hf, REG_ON_DLY, REG_ON_DLY,
		REG_LOW_DLY, REG_LOWH_DLY, REG_THRESH, REG_THRESH};
	localparam logic [31:0] RW[14] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 20000, 4000, 0, 0, 32'hfff};
	localparam logic [31:0] RV[14] = '{ON_DLY_RST, WARN_DLY_RST, HARD_DLY_RST, LOW_DLY_RST,
		LOWH_DLY_RST, THR12_RST, IRQ_MASK_RST, 0, DLY_MIN, IGN_DLY_MAX, LOW_DLY_MAX, DLY_MIN,
		THR12_MIN, THR12_MAX};

	always #10 clk_i = ~clk_i;

	vpwr_manager #(.TICK_DIV(TD)) vpwr_manager_i (.clk_i(clk_i), .rst_i(rst_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
		.avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
		.ignition_i(ign), .battery_i(bat), .sys_power_o(pwr), .pwr_button_o(btn),
		.irq_o(irq));
	vpwr_host_model vpwr_host_model_i (.clk_i(clk_i), .rst_i(rst_i), .sys_power_i(pwr),
		.pwr_button_i(btn), .rail_o(rail), .presses_o(presses));

	// ====
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d,
		input logic [3:0] b);
		@(posedge clk_i);
		rd <= !w;
		wr <= w;
		adr <= a;
		wdat <= d;
		be <= b;
		// no local limit: only the watchdog ends a hung access
		do begin
			@(posedge clk_i);
		end while (wreq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic wrx(input logic [ADR_W-1:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask
	task automatic rdx(input logic [ADR_W-1:0] a, input logic [31:0] e);
		notes.push_back(e);
		bus(1'b0, a, '0, 4'hf);
	endtask
	task automatic close_out();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// read data land in the cycle that waitrequest is low
	always @(posedge clk_i) begin
		if (rd && wreq === 1'b0 && notes.size() > 0) chk(rdat, notes.pop_front());
	end

	initial begin
		cyc(4000);
		fails++;
		close_out();
	end

	// ====
	// tests
	initial begin
		logic [31:0] r;
		logic [THR_W-1:0] lo, hi;
		r = $urandom(23938);
		lo = 12'd1000 + 12'($urandom % 100);
		hi = 12'd1200 + 12'($urandom % 200);
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 14; i++) begin
			if (i > 7) wrx(RA[i], RW[i]);
			rdx(RA[i], RV[i]);
		end
		wrx(REG_CTRL, 1);
		rdx(REG_CTRL, 1);
		rdx(REG_THRESH, THR24_RST);
		wrx(REG_THRESH, 0);
		rdx(REG_THRESH, THR24_MIN);
		wrx(REG_THRESH, 32'hfff);
		rdx(REG_THRESH, THR24_MAX);
		wrx(REG_CTRL, 0);
		rdx(REG_THRESH, THR12_RST);
		r = 1 + $urandom % 18000;
		wrx(REG_WARN_DLY, r);
		rdx(REG_WARN_DLY, r);
		// partial byte enables leave the clamped maximum in place
		bus(1'b1, REG_ON_DLY, 5, 4'h7);
		rdx(REG_ON_DLY, IGN_DLY_MAX);
		wrx(REG_ON_DLY, 2);
		wrx(REG_WARN_DLY, 3);
		wrx(REG_HARD_DLY, 2);
		wrx(REG_LOW_DLY, 3);
		wrx(REG_LOWH_DLY, 1);
		wrx(REG_IRQ_MASK, 4'hf);
		$display("test registers done");
		ign <= 1'b1;
		cyc(2 * TD - 5);
		chk(pwr, 0);
		cyc(15);
		chk(pwr, 1);
		chk(rail, 1);
		chk(irq, 1);
		rdx(REG_IRQ_STAT, 2);
		cyc(2);
		chk(irq, 0);
		// powered, ignition seen, battery fine, stage on
		rdx(REG_STATUS, 32'h23);
		ign <= 1'b0;
		cyc(2 * TD);
		ign <= 1'b1;
		cyc(10);
		ign <= 1'b0;
		cyc(45);
		chk(presses, 0);
		cyc(25);
		chk(btn, 1);
		chk(pwr, 1);
		chk(presses, 1);
		rdx(REG_COUNT, 2);
		ign <= 1'b1;
		cyc(25);
		chk(pwr, 1);
		cyc(25);
		chk(pwr, 0);
		rdx(REG_IRQ_STAT, 5);
		ign <= 1'b0;
		$display("test ignition done");
		bat <= lo;
		cyc(20);
		bat <= hi;
		wrx(REG_IRQ_MASK, 0);
		ign <= 1'b1;
		cyc(55);
		chk(pwr, 1);
		rdx(REG_IRQ_STAT, 2);
		bat <= lo;
		cyc(2 * TD);
		bat <= hi;
		cyc(5);
		bat <= lo;
		cyc(45);
		chk(presses, 1);
		cyc(25);
		chk(btn, 1);
		chk(presses, 2);
		cyc(25);
		chk(pwr, 0);
		chk(irq, 0);
		wrx(REG_IRQ_MASK, 4'hf);
		cyc(2);
		chk(irq, 1);
		rdx(REG_IRQ_STAT, 32'hd);
		cyc(2);
		chk(irq, 0);
		ign <= 1'b0;
		bat <= hi;
		$display("test battery done");
		close_out();
	end
endmodule

`default_nettype wire
